// ---- emb_mem_pkg.sv ----
// Operation
// RULE_01 - Configured as RAM, ROM, FIFO or search memory.
// RULE_02 - Input registers synchronise writes; optional output stage.
// RULE_03 - Dual port: write and read together.
// RULE_04 - Input clock captures every input-side register.
// RULE_05 - Output clock updates only read-data registers.
// RULE_06 - Each side has own enable and clear.
// RULE_07 - Fabric, global or device reset clears registers.
// RULE_08 - Single port never reads and writes together.
// RULE_09 - Each path independently registered or passed through.
// RULE_10 - Fabric drives controls synchronous to capturing clock.
// RULE_11 - Disabled side holds registers, no write or update.
// RULE_12 - Depth and width are block parameters.
package emb_mem_pkg;

    typedef enum logic [4:0]
    {
        MODE_DUAL   = 5'h01,
        MODE_SINGLE = 5'h02,
        MODE_ROM    = 5'h04,
        MODE_FIFO   = 5'h08,
        MODE_CAM    = 5'h10
    } mem_mode_t;

    // Bit positions of the per-path register selects.
    localparam int PATH_WDATA = 0;
    localparam int PATH_RDATA = 1;
    localparam int PATH_RADDR = 2;
    localparam int PATH_WADDR = 3;
    localparam int PATH_WSTRB = 4;
    localparam int PATH_RSTRB = 5;
    localparam int PATH_COUNT = 6;

    localparam int DEF_DATA_W = 16;
    localparam int DEF_ADDR_W = 8;

    localparam logic RST_STROBE = 1'b0;

endpackage

// ---- emb_mem_array.sv ----
`timescale 1ns/1ps
module emb_mem_array
    import emb_mem_pkg::*;
#(
    parameter int DW = DEF_DATA_W,
    parameter int AW = DEF_ADDR_W
)
(
    input  wire logic          clk,
    input  wire logic          clr,
    input  wire logic          we,
    input  wire logic [AW-1:0] wa,
    input  wire logic [DW-1:0] wd,
    input  wire logic          rdStrobe,
    input  wire logic [AW-1:0] ra,
    output logic      [DW-1:0] rd,
    input  wire logic          search,
    input  wire logic [DW-1:0] key,
    output logic               hitQ,
    output logic      [AW-1:0] hitAddrQ
);
    localparam int DEPTH = 1 << AW;

    logic [DW-1:0] mem [DEPTH];
    logic          hitD;
    logic [AW-1:0] hitAddrD;

    // The array itself is storage, not a register, so clears leave it intact.
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[wa] <= wd;
        end
    end

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            rd <= '0;
        end
        else if (rdStrobe)
        begin
            rd <= mem[ra];
        end
    end

    // Lowest matching word wins when several hold the key.
    always_comb
    begin
        hitD     = 1'b0;
        hitAddrD = '0;
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            if (mem[i] == key)
            begin
                hitD     = 1'b1;
                hitAddrD = AW'(i);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            hitQ     <= 1'b0;
            hitAddrQ <= '0;
        end
        else if (search)
        begin
            hitQ     <= hitD;
            hitAddrQ <= hitAddrD;
        end
    end
endmodule

// ---- embedded_memory_block.sv ----
`timescale 1ns/1ps
module embedded_memory_block
    import emb_mem_pkg::*;
#(
    // RULE_12 geometry is parameterised
    parameter int DW = DEF_DATA_W,
    parameter int AW = DEF_ADDR_W
)
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire mem_mode_t             mode,
    input  wire logic [PATH_COUNT-1:0] pathReg,
    input  wire logic                  inEn,
    input  wire logic                  outEn,
    input  wire logic                  inClr,
    input  wire logic                  outClr,
    input  wire logic                  globalClr,
    input  wire logic [DW-1:0]         wrData,
    input  wire logic [AW-1:0]         wrAddr,
    input  wire logic [AW-1:0]         rdAddr,
    input  wire logic                  memWriteStrobe,
    input  wire logic                  memReadStrobe,
    output logic      [DW-1:0]         rdData,
    output logic                       fifoFull,
    output logic                       fifoEmpty,
    output logic                       camHit,
    output logic      [AW-1:0]         camAddr
);
    logic [DW-1:0] wdQ;
    logic [AW-1:0] waQ;
    logic [AW-1:0] raQ;
    logic          weQ;
    logic          rdStbQ;
    logic [DW-1:0] outQ;
    logic [DW-1:0] memRd;
    logic [AW-1:0] wPtrQ;
    logic [AW-1:0] rPtrQ;
    logic [AW:0]   cntQ;
    logic [DW-1:0] wdE;
    logic [AW-1:0] waE;
    logic [AW-1:0] raE;
    logic          weE;
    logic          rdStbE;
    logic [AW-1:0] waUse;
    logic [AW-1:0] raUse;
    logic          wrGo;
    logic          rdGo;
    logic          searchGo;
    logic          inClear;
    logic          outClear;

    // RULE_06 separate side clears
    // RULE_07 clear sources
    assign inClear  = !rstn || globalClr || inClr;
    assign outClear = !rstn || globalClr || outClr;

    // RULE_04 input side capture
    always_ff @(posedge clk)
    begin
        if (inClear)
        begin
            wdQ <= '0;
            waQ <= '0;
            raQ <= '0;
            weQ <= RST_STROBE;
            rdStbQ <= RST_STROBE;
        end
        // RULE_11 hold when disabled
        else if (inEn)
        begin
            wdQ <= wrData;
            waQ <= wrAddr;
            raQ <= rdAddr;
            weQ <= memWriteStrobe;
            rdStbQ <= memReadStrobe;
        end
    end

    // RULE_09 per path bypass
    assign wdE = pathReg[PATH_WDATA] ? wdQ : wrData;
    assign waE = pathReg[PATH_WADDR] ? waQ : wrAddr;
    assign raE = pathReg[PATH_RADDR] ? raQ : rdAddr;
    assign weE = pathReg[PATH_WSTRB] ? weQ : memWriteStrobe;
    assign rdStbE = pathReg[PATH_RSTRB] ? rdStbQ : memReadStrobe;

    assign fifoFull  = cntQ == {1'b1, {AW{1'b0}}};
    assign fifoEmpty = cntQ == '0;

    // RULE_01 mode steers addressing and write permission
    always_comb
    begin
        // RULE_03 independent port addresses
        waUse = waE;
        raUse = raE;
        if (mode == MODE_FIFO)
        begin
            waUse = wPtrQ;
            raUse = rPtrQ;
        end
        else if (mode == MODE_SINGLE)
        begin
            raUse = waE;
        end
    end

    // RULE_11 no write while disabled
    assign wrGo = inEn && weE && (mode != MODE_ROM)
                  && !(mode == MODE_FIFO && fifoFull);

    // RULE_08 write wins in single port
    assign rdGo = inEn && rdStbE && (mode != MODE_CAM)
                  && !(mode == MODE_SINGLE && wrGo)
                  && !(mode == MODE_FIFO && fifoEmpty);

    // A read strobe in search mode starts a lookup, so the read register is left alone.
    assign searchGo = inEn && rdStbE && (mode == MODE_CAM);

    // A FIFO push and pop in one cycle leave the count unchanged.
    always_ff @(posedge clk)
    begin
        if (inClear || mode != MODE_FIFO)
        begin
            wPtrQ <= '0;
            rPtrQ <= '0;
            cntQ  <= '0;
        end
        else
        begin
            if (wrGo)
            begin
                wPtrQ <= wPtrQ + AW'(1);
            end
            if (rdGo)
            begin
                rPtrQ <= rPtrQ + AW'(1);
            end
            if (wrGo && !rdGo)
            begin
                cntQ <= cntQ + (AW+1)'(1);
            end
            else if (rdGo && !wrGo)
            begin
                cntQ <= cntQ - (AW+1)'(1);
            end
        end
    end

    // RULE_02 synchronous write array
    emb_mem_array #(
        .DW (DW),
        .AW (AW)
    ) uArray (
        .clk      (clk),
        .clr      (inClear),
        .we       (wrGo),
        .wa       (waUse),
        .wd       (wdE),
        .rdStrobe (rdGo),
        .ra       (raUse),
        .rd       (memRd),
        .search   (searchGo),
        .key      (wdE),
        .hitQ     (camHit),
        .hitAddrQ (camAddr)
    );

    // RULE_05 output stage has its own enable
    always_ff @(posedge clk)
    begin
        if (outClear)
        begin
            outQ <= '0;
        end
        else if (outEn)
        begin
            outQ <= memRd;
        end
    end

    // RULE_02 optional pipeline stage
    assign rdData = pathReg[PATH_RDATA] ? outQ : memRd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence inZero;
        wdQ == '0 && waQ == '0 && raQ == '0 && !weQ && !rdStbQ;
    endsequence

    sequence outFollows;
        outQ == $past(memRd);
    endsequence

    sequence inFollows;
        wdQ == $past(wrData) && waQ == $past(wrAddr) && raQ == $past(rdAddr);
    endsequence

    rom_no_write_a: assert property (mode == MODE_ROM |-> !wrGo) // RULE_01
        else $error("write reached array in read-only mode");
    fifo_full_a: assert property ((mode == MODE_FIFO && fifoFull) |-> !wrGo) // RULE_01
        else $error("write accepted into full fifo");
    dual_both_a: assert property ( // RULE_03
        (mode == MODE_DUAL && inEn && weE && rdStbE) |-> (wrGo && rdGo))
        else $error("dual port did not take write and read together");
    single_excl_a: assert property ((mode == MODE_SINGLE && wrGo) |-> !rdGo) // RULE_08
        else $error("single port read and write in one cycle");
    in_hold_a: assert property ( // RULE_11
        (!inEn && !inClear) |=> ($stable(wdQ) && $stable(waQ) && $stable(weQ)))
        else $error("input register moved while disabled");
    in_clear_a: assert property (inClear |=> inZero) // RULE_07
        else $error("input registers not cleared");
    out_pipe_a: assert property ((outEn && !outClear) |=> outFollows) // RULE_05
        else $error("output register did not take read data");
    out_hold_a: assert property ((!outEn && !outClear) |=> $stable(outQ)) // RULE_06
        else $error("output register moved while disabled");
    out_clear_a: assert property (outClear |=> outQ == '0) // RULE_06
        else $error("output register not cleared");
    no_write_off_a: assert property (!inEn |-> !wrGo) // RULE_11
        else $error("write while input side disabled");
    in_capture_a: assert property ((inEn && !inClear) |=> inFollows) // RULE_04
        else $error("input registers did not capture the inputs");
    fifo_push_a: assert property ( // RULE_01
        (mode == MODE_FIFO && !inClear && wrGo && !rdGo) |=> cntQ == $past(cntQ) + (AW+1)'(1))
        else $error("fifo count did not rise on a push");
    fifo_pop_a: assert property ( // RULE_01
        (mode == MODE_FIFO && !inClear && rdGo && !wrGo) |=> cntQ == $past(cntQ) - (AW+1)'(1))
        else $error("fifo count did not fall on a pop");
endmodule

// ---- fabric_logic_cell.sv ----
`timescale 1ns/1ps
module fabric_logic_cell
    import emb_mem_pkg::*;
#(
    parameter int DW = DEF_DATA_W,
    parameter int AW = DEF_ADDR_W
)
(
    input  wire logic          clk,
    output logic      [DW-1:0] wrData,
    output logic      [AW-1:0] wrAddr,
    output logic      [AW-1:0] rdAddr,
    output logic               memWriteStrobe,
    output logic               memReadStrobe
);
    initial
    begin
        wrData = '0;
        wrAddr = '0;
        rdAddr = '0;
        memWriteStrobe = 1'b0;
        memReadStrobe = 1'b0;
    end

    task automatic drive(input logic w, input logic r, input logic [AW-1:0] wa,
                         input logic [AW-1:0] ra, input logic [DW-1:0] wd);
        memWriteStrobe = w;
        memReadStrobe = r;
        wrAddr = wa;
        rdAddr = ra;
        wrData = wd;
        @(negedge clk);
    endtask

    // Released lines flip so a late capture in the block shows up as wrong data.
    task automatic idle();
        memWriteStrobe = 1'b0;
        memReadStrobe = 1'b0;
        wrAddr = ~wrAddr;
        rdAddr = ~rdAddr;
        wrData = ~wrData;
        @(negedge clk);
    endtask
endmodule

// ---- embedded_memory_block_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module embedded_memory_block_test
    import emb_mem_pkg::*;
;
    logic                  clk, rstn, inEn, outEn, inClr, outClr, globalClr;
    mem_mode_t             mode;
    logic [PATH_COUNT-1:0] pathReg;
    logic [15:0]           wrData, rdData;
    logic [7:0]            wrAddr, rdAddr, camAddr;
    logic                  memWriteStrobe, memReadStrobe, fifoFull, fifoEmpty, camHit;
    int                    errorCnt, checked, i;

    fabric_logic_cell u_fabric_logic_cell (.clk(clk), .wrData(wrData), .wrAddr(wrAddr),
        .rdAddr(rdAddr), .memWriteStrobe(memWriteStrobe), .memReadStrobe(memReadStrobe));

    embedded_memory_block u_embedded_memory_block (.clk(clk), .rstn(rstn), .mode(mode),
        .pathReg(pathReg), .inEn(inEn), .outEn(outEn), .inClr(inClr), .outClr(outClr),
        .globalClr(globalClr), .wrData(wrData), .wrAddr(wrAddr), .rdAddr(rdAddr),
        .memWriteStrobe(memWriteStrobe), .memReadStrobe(memReadStrobe), .rdData(rdData),
        .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .camHit(camHit), .camAddr(camAddr));

    always #12.5 clk = ~clk;

    task automatic op(input logic w, input logic r, input logic [7:0] wa,
                      input logic [7:0] ra, input logic [15:0] wd);
        u_fabric_logic_cell.drive(w, r, wa, ra, wd);
    endtask

    task automatic gap();
        u_fabric_logic_cell.idle();
    endtask

    task automatic completeRun();
        $display("checked=%0d mismatches=%0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        errorCnt++;
        completeRun();
    end

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        mode = MODE_DUAL;
        pathReg = '0;
        inEn = 1'b1;
        outEn = 1'b1;
        inClr = 1'b0;
        outClr = 1'b0;
        globalClr = 1'b0;
        errorCnt = 0;
        checked = 0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        `CHK({rdData, fifoEmpty, fifoFull, camHit}, {16'h0000, 3'b100})
        op(1'b1, 1'b0, 8'h03, 8'h00, 16'hA5C3);
        op(1'b1, 1'b1, 8'h04, 8'h03, 16'h5A3C);
        `CHK(rdData, 16'hA5C3)
        op(1'b0, 1'b1, 8'h00, 8'h04, 16'h0000);
        `CHK(rdData, 16'h5A3C)
        inEn = 1'b0;
        op(1'b1, 1'b1, 8'h03, 8'h03, 16'hFFFF);
        `CHK(rdData, 16'h5A3C)
        inEn = 1'b1;
        op(1'b0, 1'b1, 8'h00, 8'h03, 16'h0000);
        `CHK(rdData, 16'hA5C3)
        $display("dual port test done");
        pathReg = 6'h3D;
        op(1'b1, 1'b0, 8'h05, 8'h00, 16'h1357);
        gap();
        op(1'b0, 1'b1, 8'h00, 8'h05, 16'h0000);
        `CHK(rdData, 16'hA5C3)
        gap();
        `CHK(rdData, 16'h1357)
        pathReg = 6'h02;
        op(1'b0, 1'b1, 8'h00, 8'h04, 16'h0000);
        gap();
        `CHK(rdData, 16'h5A3C)
        outEn = 1'b0;
        op(1'b0, 1'b1, 8'h00, 8'h03, 16'h0000);
        gap();
        `CHK(rdData, 16'h5A3C)
        outEn = 1'b1;
        gap();
        `CHK(rdData, 16'hA5C3)
        outClr = 1'b1;
        gap();
        `CHK(rdData, 16'h0000)
        outClr = 1'b0;
        globalClr = 1'b1;
        gap();
        globalClr = 1'b0;
        gap();
        `CHK(rdData, 16'h0000)
        $display("output register test done");
        pathReg = '0;
        mode = MODE_SINGLE;
        op(1'b1, 1'b1, 8'h10, 8'h10, 16'h1111);
        `CHK(rdData, 16'h0000)
        op(1'b0, 1'b1, 8'h10, 8'h10, 16'h0000);
        `CHK(rdData, 16'h1111)
        mode = MODE_ROM;
        op(1'b1, 1'b0, 8'h10, 8'h10, 16'h2222);
        op(1'b0, 1'b1, 8'h10, 8'h10, 16'h0000);
        `CHK(rdData, 16'h1111)
        $display("single port and rom test done");
        mode = MODE_FIFO;
        `CHK(fifoEmpty, 1'b1)
        for (i = 0; i < 257; i++)
            op(1'b1, 1'b0, 8'h00, 8'h00, i[15:0]);
        `CHK({fifoFull, fifoEmpty}, 2'b10)
        for (i = 0; i < 256; i++)
        begin
            op(1'b0, 1'b1, 8'h00, 8'h00, 16'h0000);
            `CHK(rdData, i[15:0])
        end
        op(1'b0, 1'b1, 8'h00, 8'h00, 16'h0000);
        `CHK({rdData, fifoEmpty}, {16'h00FF, 1'b1})
        $display("fifo test done");
        mode = MODE_CAM;
        op(1'b1, 1'b0, 8'h21, 8'h00, 16'hBEEF);
        op(1'b1, 1'b0, 8'h22, 8'h00, 16'hBEEF);
        op(1'b0, 1'b1, 8'h00, 8'h00, 16'hBEEF);
        `CHK({camHit, camAddr}, {1'b1, 8'h21})
        op(1'b0, 1'b1, 8'h00, 8'h00, 16'h1234);
        `CHK(camHit, 1'b0)
        gap();
        $display("search test done");
        completeRun();
    end
endmodule
